/* core/cld_pkg.sv */
package cld_pkg;
  // ---------------------------------------------------------------
  // sizes and bus map
  // ---------------------------------------------------------------
  localparam int PCW = 20;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_PWR_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam int ST_WR_BIT = 0;
  localparam int ST_TO_BIT = 1;
  localparam int ST_PD_BIT = 2;
  localparam int ST_FSM_LSB = 3;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  localparam logic [7:0] TIMER_ZERO_ADR_DEF = 8'h10;
  localparam logic [7:0] PORT_B_REGISTER_ADR_DEF = 8'h11;
  // table write with an internal memory launch lasts this many cycles
  localparam int PROGRAM_MEM_WRITE_LONG_CYC = 5;
  localparam logic [2:0] TBLW_WAIT = 3'(PROGRAM_MEM_WRITE_LONG_CYC - 2);
  // flag update masks, order {c, dc, z, ov, n}
  localparam logic [4:0] FLG_NONE = 5'h00;
  localparam logic [4:0] FLG_ARITH = 5'h1f;
  localparam logic [4:0] FLG_ZN = 5'h05;
  localparam logic [4:0] FLG_C = 5'h10;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_BRANCH = 5'h01, OP_CALL_REL = 5'h02,
    OP_GOTO = 5'h03, OP_CALL = 5'h04, OP_SLEEP = 5'h05,
    OP_WDT = 5'h06, OP_PUSH = 5'h07, OP_POP = 5'h08,
    OP_DAW = 5'h09, OP_RESET = 5'h0a, OP_RETURN_IRQ = 5'h0b,
    OP_RETURN = 5'h0c, OP_RETURN_WITH_IMM = 5'h0d, OP_ADD = 5'h0e,
    OP_SUB = 5'h0f, OP_AND = 5'h10, OP_IOR = 5'h11,
    OP_XOR = 5'h12, OP_LOAD_IMMEDIATE = 5'h13, OP_MUL = 5'h14,
    OP_LOAD_BANK_IMM = 5'h15, OP_LOAD_POINTER_IMM = 5'h16, OP_PROGRAM_MEM_READ = 5'h17,
    OP_PROGRAM_MEM_WRITE = 5'h18, OP_FILE = 5'h19
  } cld_op_t;
  typedef enum logic [1:0] {
    S_EXEC = 2'b00, S_WORD2 = 2'b01, S_BUBBLE = 2'b10, S_TBLW = 2'b11
  } cld_state_t;
  typedef struct packed {
    logic z;
    logic c;
    logic ov;
    logic n;
  } cld_flags_t;
  typedef struct packed {
    cld_op_t op;
    logic [7:0] lit;
    logic [4:0] flag_upd;
    logic pc_load;
    logic [PCW-1:0] target;
    logic fast;
    logic [1:0] sel;
    logic [11:0] wide_lit;
  } cld_ctrl_t;
  localparam cld_ctrl_t CTRL_IDLE = '{OP_NOP, 8'h00, 5'h00, 1'b0, '0, 1'b0,
    2'h0, 12'h000};
endpackage

/* core/cld_decoder.sv */
// Notes on behaviour
// - 1110_0ccc: eight conditional branches, 1 or 2
// - 1101 0/1: relative jump and relative call
// - absolute jump and call use two words
// - lone 1111 word executes as no-op
// - pc change or true test adds nop cycle, except two-word jump and call
// - standby and watchdog kick set status flags
// - nop, push, pop, decimal adjust, software reset
// - interrupt return, two cycles, fast select bit
// - subroutine return, return with immediate, two cycles
// - add immediate updates all five flags
// - subtract accumulator from immediate, all five flags
// - and/or/xor immediate update zero, negative only
// - load and multiply immediate touch no flags
// - load bank immediate into low bank bits
// - two-word pointer load of twelve-bit immediate
// - program memory read with four pointer modes
// - program memory write, longer when launching write
// - launched internal write runs until terminated
// - port read-modify-write uses synced pin levels
// - timer zero write clears assigned prescaler
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module cld_decoder import cld_pkg::*; #(
  parameter logic [7:0] TIMER_ZERO_ADR = TIMER_ZERO_ADR_DEF,
  parameter logic [7:0] PORT_B_REGISTER_ADR = PORT_B_REGISTER_ADR_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [PCW-1:0] instr_addr_i,
  input wire cld_flags_t flags_i,
  input wire logic presc_assigned_i,
  input wire logic prog_wr_done_i,
  input wire logic [7:0] port_pins_i,
  output cld_ctrl_t ctrl_o,
  output logic fetch_hold_o,
  output logic port_rmw_o,
  output logic [7:0] port_rmw_data_o,
  output logic presc_clr_o,
  output logic prog_wr_active_o,
  output logic wdt_expired_flag_o,
  output logic powerdown_flag_o
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic cld_op_t decode_op(input logic [15:0] w);
    cld_op_t op;
    op = OP_NOP;
    case (w[15:12])
      4'he: begin
        if (!w[11]) begin
          op = OP_BRANCH;
        end else if (w[10:9] == 2'b10) begin
          op = OP_CALL;
        end else if (w[10:8] == 3'b111) begin
          op = OP_GOTO;
        end else if (w[10:8] == 3'b110 && w[7:6] == 2'b00) begin
          op = OP_LOAD_POINTER_IMM;
        end
      end
      4'hd: op = w[11] ? OP_CALL_REL : OP_BRANCH;
      4'hf: op = OP_NOP;
      4'h0: begin
        case (w[11:8])
          4'h0: begin
            case (w[7:0])
              8'h03: op = OP_SLEEP;
              8'h04: op = OP_WDT;
              8'h05: op = OP_PUSH;
              8'h06: op = OP_POP;
              8'h07: op = OP_DAW;
              8'h08, 8'h09, 8'h0a, 8'h0b: op = OP_PROGRAM_MEM_READ;
              8'h0c, 8'h0d, 8'h0e, 8'h0f: op = OP_PROGRAM_MEM_WRITE;
              8'h10, 8'h11: op = OP_RETURN_IRQ;
              8'h12, 8'h13: op = OP_RETURN;
              8'hff: op = OP_RESET;
              default: op = OP_NOP;
            endcase
          end
          4'h1: op = (w[7:4] == 4'h0) ? OP_LOAD_BANK_IMM : OP_NOP;
          4'h8: op = OP_SUB;
          4'h9: op = OP_IOR;
          4'ha: op = OP_XOR;
          4'hb: op = OP_AND;
          4'hc: op = OP_RETURN_WITH_IMM;
          4'hd: op = OP_MUL;
          4'he: op = OP_LOAD_IMMEDIATE;
          4'hf: op = OP_ADD;
          default: op = OP_FILE;
        endcase
      end
      default: op = OP_FILE;
    endcase
    return op;
  endfunction

  // ccc: bit0 inverts, bits 2:1 pick zero, carry, overflow, negative
  function automatic logic cond_met(input logic [2:0] cc,
                                    input cld_flags_t f);
    logic b;
    case (cc[2:1])
      2'd0: b = f.z;
      2'd1: b = f.c;
      2'd2: b = f.ov;
      default: b = f.n;
    endcase
    return b ^ cc[0];
  endfunction

  // file ops that read f and write it back (d = 1, or bit ops)
  function automatic logic file_rmw(input logic [15:0] w);
    logic dop;
    dop = (w[15:12] >= 4'h1 && w[15:12] <= 4'h5) || (w[15:10] == 6'b000001);
    return (dop && w[9]) || (w[15:12] >= 4'h7 && w[15:12] <= 4'h9);
  endfunction

  // ---------------------------------------------------------------
  // decode of the current word
  // ---------------------------------------------------------------
  cld_state_t state;
  cld_state_t next_state;
  cld_ctrl_t next_ctrl;
  logic [2:0] wait_cnt;
  logic [2:0] next_wait;
  logic [15:0] first_word;
  logic [1:0] ctl_reg;
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;
  logic wb_req;
  logic [31:0] stat_word;
  cld_op_t op_now;
  cld_op_t op_first;
  logic take;
  logic is_cond;
  logic is_rel;
  logic taken;
  logic [PCW-1:0] next_addr;
  logic [PCW-1:0] rel8_tgt;
  logic [PCW-1:0] rel11_tgt;

  assign take = instr_valid_i && ctl_reg[CTRL_RUN_BIT] && (state == S_EXEC);
  assign op_now = decode_op(instr_i);
  assign op_first = decode_op(first_word);
  assign is_cond = (instr_i[15:11] == 5'b11100);
  assign is_rel = (instr_i[15:12] == 4'hd);
  assign taken = is_rel || (is_cond && cond_met(instr_i[10:8], flags_i));
  // signed word offsets from the following word
  assign next_addr = instr_addr_i + PCW'(1);
  assign rel8_tgt = next_addr + {{(PCW-8){instr_i[7]}}, instr_i[7:0]};
  assign rel11_tgt = next_addr + {{(PCW-11){instr_i[10]}}, instr_i[10:0]};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next control word, next state and stall count
  always_comb begin
    next_ctrl = CTRL_IDLE;
    next_state = state;
    next_wait = wait_cnt;
    case (state)
      S_EXEC: begin
        if (take) begin
          next_ctrl.op = op_now;
          next_ctrl.lit = instr_i[7:0];
          next_ctrl.fast = instr_i[0];
          next_ctrl.sel = instr_i[1:0];
          case (op_now)
            OP_ADD, OP_SUB: next_ctrl.flag_upd = FLG_ARITH;
            OP_AND, OP_IOR, OP_XOR: next_ctrl.flag_upd = FLG_ZN;
            OP_DAW: next_ctrl.flag_upd = FLG_C;
            default: next_ctrl.flag_upd = FLG_NONE;
          endcase
          case (op_now)
            OP_BRANCH: begin
              next_ctrl.pc_load = taken;
              next_ctrl.target = is_rel ? rel11_tgt : rel8_tgt;
              if (taken) begin
                next_state = S_BUBBLE;
              end
            end
            OP_CALL_REL: begin
              next_ctrl.pc_load = 1'b1;
              next_ctrl.target = rel11_tgt;
              next_state = S_BUBBLE;
            end
            OP_GOTO, OP_CALL, OP_LOAD_POINTER_IMM: begin
              // hold back until the operand word arrives
              next_ctrl = CTRL_IDLE;
              next_state = S_WORD2;
            end
            OP_RETURN_IRQ, OP_RETURN, OP_RETURN_WITH_IMM: begin
              next_ctrl.pc_load = 1'b1;
              next_state = S_BUBBLE;
            end
            OP_PROGRAM_MEM_READ: next_state = S_BUBBLE;
            OP_PROGRAM_MEM_WRITE: begin
              if (ctl_reg[CTRL_PWR_BIT]) begin
                next_state = S_TBLW;
                next_wait = TBLW_WAIT;
              end else begin
                next_state = S_BUBBLE;
              end
            end
            default: next_state = S_EXEC;
          endcase
        end
      end
      S_WORD2: begin
        if (instr_valid_i) begin
          next_state = S_EXEC;
          // a malformed second word aborts the pair as a nop
          if (instr_i[15:12] == 4'hf) begin
            next_ctrl.op = op_first;
            next_ctrl.pc_load = (op_first != OP_LOAD_POINTER_IMM);
            next_ctrl.target = {instr_i[11:0], first_word[7:0]};
            next_ctrl.fast = first_word[8];
            next_ctrl.sel = first_word[5:4];
            next_ctrl.wide_lit = {first_word[3:0], instr_i[7:0]};
          end
        end
      end
      S_BUBBLE: next_state = S_EXEC;
      S_TBLW: begin
        if (wait_cnt == 3'h0) begin
          next_state = S_EXEC;
        end else begin
          next_wait = wait_cnt - 3'h1;
        end
      end
      default: next_state = S_EXEC;
    endcase
  end

  // state, stall and control word; software reset restarts decode
  always_ff @(posedge clk_i) begin
    if (rst_i || ctrl_o.op == OP_RESET) begin
      state <= S_EXEC;
      wait_cnt <= 3'h0;
      ctrl_o <= CTRL_IDLE;
      fetch_hold_o <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait;
      ctrl_o <= next_ctrl;
      fetch_hold_o <= (next_state == S_BUBBLE) || (next_state == S_TBLW);
    end
  end

  // first word of a pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_word <= 16'h0000;
    end else if (take) begin
      first_word <= instr_i;
    end
  end

  // ---------------------------------------------------------------
  // status flags and internal write tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_expired_flag_o <= TO_RST;
      powerdown_flag_o <= PD_RST;
    end else if (take && op_now == OP_SLEEP) begin
      wdt_expired_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b0;
    end else if (take && op_now == OP_WDT) begin
      wdt_expired_flag_o <= 1'b1;
      powerdown_flag_o <= 1'b1;
    end
  end

  // a launch in the same cycle as done keeps the write running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_wr_active_o <= 1'b0;
    end else if (take && op_now == OP_PROGRAM_MEM_WRITE && ctl_reg[CTRL_PWR_BIT]) begin
      prog_wr_active_o <= 1'b1;
    end else if (prog_wr_done_i) begin
      prog_wr_active_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // port and timer side effects of file ops
  // ---------------------------------------------------------------
  // pins are asynchronous; only the second stage is used
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
    end else begin
      pins_meta <= port_pins_i;
      pins_sync <= pins_meta;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_rmw_o <= 1'b0;
      port_rmw_data_o <= 8'h00;
      presc_clr_o <= 1'b0;
    end else begin
      port_rmw_o <= take && op_now == OP_FILE && file_rmw(instr_i) &&
                    !instr_i[8] && instr_i[7:0] == PORT_B_REGISTER_ADR;
      port_rmw_data_o <= pins_sync;
      presc_clr_o <= take && op_now == OP_FILE && presc_assigned_i && !instr_i[8] &&
                     instr_i[7:0] == TIMER_ZERO_ADR &&
                     (file_rmw(instr_i) || instr_i[15:11] == 5'b01101);
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_WR_BIT] = prog_wr_active_o;
    stat_word[ST_TO_BIT] = wdt_expired_flag_o;
    stat_word[ST_PD_BIT] = powerdown_flag_o;
    stat_word[ST_FSM_LSB +: 2] = state;
  end

  // one wait state; unmapped offsets ack and read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctl_reg <= CTRL_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
        ctl_reg <= wb_dat_i[1:0];
      end
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= {30'h0, ctl_reg};
        ADR_STAT: wb_dat_o <= stat_word;
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_cond_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_cond && cond_met(instr_i[10:8], flags_i) |=>
    ctrl_o.pc_load && fetch_hold_o ##1 ctrl_o.op == OP_NOP && !fetch_hold_o)
    else $error("taken branch lacks its nop cycle");
  chk_cond_fall: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_cond && !cond_met(instr_i[10:8], flags_i) |=>
    !ctrl_o.pc_load && !fetch_hold_o)
    else $error("untaken branch took two cycles");
  chk_rel_target: assert property (@(posedge clk_i) disable iff (rst_i)
    take && is_rel |=> ctrl_o.target == $past(rel11_tgt) && ctrl_o.pc_load)
    else $error("relative target wrong");
  chk_pair_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_WORD2 && instr_valid_i && instr_i[15:12] == 4'hf &&
    op_first == OP_GOTO |=> ctrl_o.pc_load && !fetch_hold_o &&
    ctrl_o.target == {$past(instr_i[11:0]), $past(first_word[7:0])})
    else $error("absolute jump target wrong");
  chk_lone_second: assert property (@(posedge clk_i) disable iff (rst_i)
    take && instr_i[15:12] == 4'hf |=> ctrl_o.op == OP_NOP && !ctrl_o.pc_load)
    else $error("lone operand word not a nop");
  chk_sleep_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    take && instr_i == 16'h0003 |=> wdt_expired_flag_o && !powerdown_flag_o)
    else $error("standby flags wrong");
  chk_add_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    take && instr_i[15:8] == 8'h0f |=> ctrl_o.op == OP_ADD && ctrl_o.flag_upd == FLG_ARITH)
    else $error("add immediate flags wrong");
  chk_logic_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    take && instr_i[15:10] == 6'b000010 && instr_i[9:8] != 2'b00 |=>
    ctrl_o.flag_upd == FLG_ZN)
    else $error("logic immediate flags wrong");
  chk_program_mem_write_long: assert property (@(posedge clk_i) disable iff (rst_i)
    take && op_now == OP_PROGRAM_MEM_WRITE && ctl_reg[CTRL_PWR_BIT] |=>
    fetch_hold_o [*4] ##1 !fetch_hold_o)
    else $error("launching table write not five cycles");
  chk_wr_running: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_wr_active_o && !prog_wr_done_i |=> prog_wr_active_o)
    else $error("internal write ended early");
endmodule // cld_decoder

/* bench/cld_core_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// program memory and datapath stand-in
// ----------------------------------------
module cld_core_model import cld_pkg::*; #(
  parameter int WR_LAT = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [15:0] word_i,
  input wire logic [PCW-1:0] addr_i,
  input wire logic hold_i,
  input wire logic wr_active_i,
  output logic instr_valid_o,
  output logic [15:0] instr_o,
  output logic [PCW-1:0] instr_addr_o,
  output logic prog_wr_done_o
);
  logic [15:0] junk;
  logic [3:0] wr_cnt;
  // idle bus walks a pattern so a stale word never looks valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      junk <= 16'h5a3c;
    end else begin
      junk <= {junk[14:0], ~junk[15]};
    end
  end
  // no word is offered while the sequencer stalls fetch
  assign instr_valid_o = req_i & ~hold_i;
  assign instr_o = instr_valid_o ? word_i : junk;
  assign instr_addr_o = instr_valid_o ? addr_i : {junk[3:0], junk};
  // memory write outlives the instruction that launched it
  always_ff @(posedge clk_i) begin
    if (rst_i || !wr_active_i) begin
      wr_cnt <= 4'h0;
    end else begin
      wr_cnt <= wr_cnt + 4'h1;
    end
  end
  assign prog_wr_done_o = (wr_cnt == 4'(WR_LAT));
endmodule // cld_core_model

/* bench/tb.sv */
`timescale 1ns/10ps
module tb import cld_pkg::*;;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, r;
  logic instr_valid_i, presc_assigned_i, prog_wr_done_i, req, tk, pv;
  logic [15:0] instr_i, word, w1, w2, pw;
  logic [PCW-1:0] instr_addr_i, pcv, tgt;
  cld_flags_t flags_i;
  cld_ctrl_t ctrl_o;
  logic [7:0] port_pins_i, port_rmw_data_o;
  logic fetch_hold_o, port_rmw_o, presc_clr_o, prog_wr_active_o;
  logic wdt_expired_flag_o, powerdown_flag_o;
  int seed = 44;
  int fails = 0;
  int num_checks = 0;
  int i, k, n, pi;
  localparam int NT = 29;
  // single-word encodings and their expected operation
  logic [15:0] tw [NT] = '{16'h0f00, 16'h0800, 16'h0b00, 16'h0900, 16'h0a00, 16'h0e00,
    16'h0d00, 16'h0c00, 16'h0100, 16'hf000, 16'h0000, 16'h0003, 16'h0004, 16'h0005,
    16'h0006, 16'h0007, 16'h00ff, 16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0008,
    16'h0009, 16'h000a, 16'h000b, 16'h000c, 16'h000d, 16'h000e, 16'h000f};
  cld_op_t top [NT] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_LOAD_IMMEDIATE, OP_MUL, OP_RETURN_WITH_IMM,
    OP_LOAD_BANK_IMM, OP_NOP, OP_NOP, OP_SLEEP, OP_WDT, OP_PUSH, OP_POP, OP_DAW, OP_RESET,
    OP_RETURN_IRQ, OP_RETURN_IRQ, OP_RETURN, OP_RETURN, OP_PROGRAM_MEM_READ, OP_PROGRAM_MEM_READ, OP_PROGRAM_MEM_READ, OP_PROGRAM_MEM_READ,
    OP_PROGRAM_MEM_WRITE, OP_PROGRAM_MEM_WRITE, OP_PROGRAM_MEM_WRITE, OP_PROGRAM_MEM_WRITE};

  cld_decoder u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_valid_i, .instr_i, .instr_addr_i, .flags_i,
    .presc_assigned_i, .prog_wr_done_i, .port_pins_i, .ctrl_o, .fetch_hold_o, .port_rmw_o,
    .port_rmw_data_o, .presc_clr_o, .prog_wr_active_o, .wdt_expired_flag_o,
    .powerdown_flag_o);
  cld_core_model u_mem (.clk_i, .rst_i, .req_i(req), .word_i(word), .addr_i(pcv),
    .hold_i(fetch_hold_o), .wr_active_i(prog_wr_active_o), .instr_valid_o(instr_valid_i),
    .instr_o(instr_i), .instr_addr_o(instr_addr_i), .prog_wr_done_o(prog_wr_done_i));

  // ----------------------------------------
  // expectations, compare and bus helpers
  // ----------------------------------------
  function automatic logic held(input cld_op_t op);
    return op inside {OP_RETURN_WITH_IMM, OP_RETURN_IRQ, OP_RETURN, OP_PROGRAM_MEM_READ, OP_PROGRAM_MEM_WRITE};
  endfunction
  function automatic logic [4:0] fmask(input cld_op_t op);
    if (op inside {OP_ADD, OP_SUB}) return FLG_ARITH;
    if (op inside {OP_AND, OP_IOR, OP_XOR}) return FLG_ZN;
    return (op == OP_DAW) ? FLG_C : FLG_NONE;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", what, e, g);
    end
  endtask
  // a word handed over here is taken at the next edge; ctrl_o then shows the one before
  task automatic st(input logic v, input logic [15:0] w);
    @(posedge clk_i);
    req <= v;
    word <= w;
    #1;
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    // a slave that never answers ends the run here
    if (n == 20) begin
      fails++;
      conclude();
    end
  endtask
  task automatic chkc(input logic [15:0] w, input cld_op_t op);
    chk("op", 32'(op), 32'(ctrl_o.op));
    chk("hold", 32'(held(op)), 32'(fetch_hold_o));
    if (op != OP_RESET) chk("flag_upd", 32'(fmask(op)), 32'(ctrl_o.flag_upd));
    if (w[15:11] == 5'h01) chk("lit", 32'(w[7:0]), 32'(ctrl_o.lit));
    if (op == OP_LOAD_BANK_IMM) chk("bank", 32'(w[3:0]), 32'(ctrl_o.lit));
    if (op inside {OP_RETURN_IRQ, OP_RETURN}) chk("fast", 32'(w[0]), 32'(ctrl_o.fast));
    if (op inside {OP_PROGRAM_MEM_READ, OP_PROGRAM_MEM_WRITE}) chk("mode", 32'(w[1:0]), 32'(ctrl_o.sel));
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req, presc_assigned_i} = 6'h20;
    {wb_adr_i, wb_sel_i, wb_dat_i, word, pcv, port_pins_i} = '0;
    flags_i = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // register map: reset values, unmapped place, lane-gated write
    wb(1'b0, ADR_STAT, 32'h0, 4'hf);
    chk("stat_rst", {29'h0, PD_RST, TO_RST, 1'b0}, q);
    wb(1'b1, ADR_CTRL, 32'h0, 4'h0);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    chk("ctrl_rst", 32'(CTRL_RST), q);
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    // every single-word form once, then a random mix, back to back
    pv = 1'b0;
    for (k = 0; k < 90; k++) begin
      r = $random(seed);
      flags_i <= r[31:28];
      i = (k < NT) ? k : int'($unsigned($random(seed)) % NT);
      w1 = tw[i];
      if (w1[15:12] == 4'hf) w1[11:0] = r[11:0];
      else if (w1[11]) w1[7:0] = r[7:0];
      else if (w1[8]) w1[3:0] = r[3:0];
      st(1'b1, w1);
      if (pv) chkc(pw, top[pi]);
      {pw, pi, pv} = {w1, i, 1'b1};
      // stall cycle after multi-cycle ops and after software reset
      if (held(top[i]) || top[i] == OP_RESET) begin
        st(1'b0, w1);
        chkc(pw, top[pi]);
        pv = 1'b0;
      end
    end
    st(1'b0, 16'h0);
    if (pv) chkc(pw, top[pi]);
    // standby then watchdog kick: status flag pair
    for (k = 0; k < 2; k++) begin
      st(1'b1, k ? 16'h0004 : 16'h0003);
      st(1'b0, 16'h0);
      wb(1'b0, ADR_STAT, 32'h0, 4'hf);
      chk("to_pd", k ? 32'h3 : 32'h1, 32'(q[ST_PD_BIT:ST_TO_BIT]));
      chk("to_pd_pin", k ? 32'h3 : 32'h1, 32'({powerdown_flag_o, wdt_expired_flag_o}));
    end
    // conditional and relative branches with random flags and offsets
    for (k = 0; k < 40; k++) begin
      r = $random(seed);
      i = k % 10;
      flags_i <= r[23:20];
      pcv <= r[27:8];
      w1 = (i < 8) ? {5'h1c, i[2:0], r[7:0]} : {4'hd, i[0], r[10:0]};
      tk = (i < 8) ? (r[23 - i / 2] ^ i[0]) : 1'b1;
      tgt = r[27:8] + 20'h1 + ((i < 8) ? {{12{r[7]}}, r[7:0]} : {{9{r[10]}}, r[10:0]});
      st(1'b1, w1);
      st(1'b0, w1);
      chk("br_op", 32'((i == 9) ? OP_CALL_REL : OP_BRANCH), 32'(ctrl_o.op));
      chk("br_load", 32'(tk), 32'(ctrl_o.pc_load));
      chk("br_hold", 32'(tk), 32'(fetch_hold_o));
      chk("br_flags", 32'(FLG_NONE), 32'(ctrl_o.flag_upd));
      if (tk) chk("br_tgt", 32'(tgt), 32'(ctrl_o.target));
    end
    // two-word forms: jump, call, pointer load, and an aborted pair
    for (k = 0; k < 12; k++) begin
      r = $random(seed);
      i = k % 4;
      w1 = (i == 1) ? {7'h76, r[20], r[7:0]} : (i == 2) ? {10'h3b8, r[17:16], r[11:8]}
        : {8'hef, r[7:0]};
      w2 = (i == 2) ? {8'hf0, r[7:0]} : (i == 3) ? 16'h0e55 : {4'hf, r[31:20]};
      st(1'b1, w1);
      st(1'b1, w2);
      chk("w1_op", 32'(OP_NOP), 32'(ctrl_o.op));
      st(1'b0, w2);
      chk("w2_op", 32'(i == 0 ? OP_GOTO : i == 1 ? OP_CALL : i == 2 ? OP_LOAD_POINTER_IMM : OP_NOP),
        32'(ctrl_o.op));
      chk("w2_load", 32'(i < 2), 32'(ctrl_o.pc_load));
      if (i < 2) chk("w2_tgt", 32'({w2[11:0], w1[7:0]}), 32'(ctrl_o.target));
      if (i == 1) chk("w2_fast", 32'(w1[8]), 32'(ctrl_o.fast));
      if (i == 2) chk("ptr", 32'({w1[5:0], w2[7:0]}), 32'({ctrl_o.sel, ctrl_o.wide_lit}));
    end
    // table write launching an internal write
    wb(1'b1, ADR_CTRL, 32'h3, 4'h1);
    st(1'b1, 16'h000d);
    st(1'b0, 16'h0);
    chk("wt_op", 32'(OP_PROGRAM_MEM_WRITE), 32'(ctrl_o.op));
    for (n = 1; n < 20 && fetch_hold_o === 1'b1; n++) st(1'b0, 16'h0);
    chk("wt_cycles", 32'(PROGRAM_MEM_WRITE_LONG_CYC), 32'(n));
    chk("wr_running", 32'h1, 32'(prog_wr_active_o));
    // the running write is visible in the status word as well
    wb(1'b0, ADR_STAT, 32'h0, 4'hf);
    chk("stat_wr", 32'h1, 32'(q[ST_WR_BIT]));
    for (k = 0; k < 30 && prog_wr_active_o === 1'b1; k++) st(1'b0, 16'h0);
    chk("wr_ended", 32'h0, 32'(prog_wr_active_o));
    // run off: a fetched word is dropped and leaves no trace
    wb(1'b1, ADR_CTRL, 32'h0, 4'h1);
    st(1'b1, 16'h0e5a);
    st(1'b0, 16'h0);
    chk("run_off", 32'(OP_NOP), 32'(ctrl_o.op));
    wb(1'b1, ADR_CTRL, 32'h1, 4'h1);
    // port rewrite from pins, timer-zero prescaler clear
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      port_pins_i <= r[7:0];
      presc_assigned_i <= r[8];
      repeat (4) st(1'b0, 16'h0);
      for (k = 0; k < 3; k++) begin
        w1 = (k == 0) ? {8'h52, PORT_B_REGISTER_ADR_DEF} : {k == 1 ? 8'h26 : 8'h24, TIMER_ZERO_ADR_DEF};
        st(1'b1, w1);
        st(1'b0, w1);
        chk("file_op", 32'(OP_FILE), 32'(ctrl_o.op));
        chk("rmw", 32'(k == 0), 32'(port_rmw_o));
        if (k == 0) chk("rmw_data", 32'(r[7:0]), 32'(port_rmw_data_o));
        chk("presc_clr", 32'(k == 1 && r[8]), 32'(presc_clr_o));
      end
    end
    conclude();
  end
endmodule // tb
